// >>> verilog/smg_pkg.sv
// Purpose: shared constants and carrier types for the sleep mode clock gating block
// Assumes: one system clock; peripheral bits ordered as in the power-reduction byte
// Notes: all codes and counts used by more than one file live here

package smg_pkg;

    // sleep mode select codes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_ADCNR = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_RSV4 = 3'h4;
    localparam logic [2:0] MODE_RSV5 = 3'h5;
    localparam logic [2:0] MODE_STBY = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;

    // wake timing in system clock cycles
    localparam int HALT_CYC = 4;
    localparam int STBY_WAKE_CYC = 6;
    localparam int START_SHORT_CYC = 1024;
    localparam int NOSTOP_WAKE_CYC = 1;
    localparam int WAKE_W = 17;

    // fuse and status word decoding
    localparam logic [2:0] BOD_FUSE_OFF = 3'h7;
    localparam int CKSRC_XTAL_BIT = 3;
    localparam int SUT_LONG_BIT = 1;
    localparam logic [1:0] SUT_SHORT = 2'h0;
    localparam int PSW_GIE_BIT = 7;

    // peripheral clock-off bit positions
    localparam int NPERIPH = 8;
    localparam int PR_ADC = 0;
    localparam int PR_TIM2 = 6;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_START = 2'b10,
        ST_HALT = 2'b11
    } smg_state_e;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
        logic t2_sync;
    } smg_clk_s;

    typedef struct packed {
        logic ext_reset;
        logic wdt_reset;
        logic wdt_irq;
        logic bod_reset;
        logic twi_match;
        logic ext_irq_zero;
        logic ext_irq_one;
        logic pin_change;
        logic other_irq;
    } smg_wake_s;

    typedef struct packed {
        logic enabled;
        logic async_clk;
        logic sync_clk;
        logic [2:0] timer2_irq_mask;
        logic [2:0] evt;
    } smg_t2_s;

    localparam smg_clk_s CLK_ALL_ON = smg_clk_s'(8'hFF);

endpackage

// >>> verilog/smg_wake_timer.sv
// Purpose: start-up delay counter used while clocks restart after a wake
// Assumes: load_val is at least one
// Notes: last is high in the final cycle of the loaded period

`timescale 1ns/10ps

module smg_wake_timer #(
    parameter int W = smg_pkg::WAKE_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic last
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // count down to zero and rest there
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    assign last = (cnt_q == W'(1));
endmodule // smg_wake_timer

// >>> verilog/smg_periph_gate.sv
// Purpose: per-peripheral clock shutdown and register access blocking
// Assumes: domain run levels come from the sleep controller
// Notes: a stopped clock keeps the peripheral's state, so restart resumes it

`timescale 1ns/10ps

module smg_periph_gate #(
    parameter int N = smg_pkg::NPERIPH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [N-1:0] clk_off,
    input wire logic io_run,
    input wire logic adc_run,
    input wire logic asy_run,
    input wire logic t2_async,
    input wire logic [N-1:0] reg_req,
    output logic [N-1:0] pclk_en_q,
    output logic [N-1:0] grant_q
);
    logic [N-1:0] pclk_en_d;
    logic [N-1:0] grant_d;

    // timer 2 on its own oscillator is not stopped by its bit
    for (genvar i = 0; i < N; i++) begin : g_per
        logic async_t2;
        logic run;
        logic off;
        assign async_t2 = (i == smg_pkg::PR_TIM2) && t2_async;
        assign run = (i == smg_pkg::PR_ADC) ? adc_run : (async_t2 ? asy_run : io_run);
        assign off = clk_off[i] && !async_t2;
        assign pclk_en_d[i] = run && !off;
        assign grant_d[i] = reg_req[i] && !off;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_en_q <= '0;
            grant_q <= '0;
        end else if (ce) begin
            pclk_en_q <= pclk_en_d;
            grant_q <= grant_d;
        end
    end

    AST_PR_BLOCK: assert property (@(posedge clk) disable iff (!rst_n || !ce)
        clk_off[smg_pkg::PR_ADC] |=> !pclk_en_q[smg_pkg::PR_ADC] && !grant_q[smg_pkg::PR_ADC])
        else $error("stopped peripheral still clocked or accessible");
endmodule // smg_periph_gate

// >>> verilog/smg_top.sv
// Purpose: sleep mode controller gating clock domains, oscillators and analog helpers
// Assumes: SLEEP_INSTR is a one-cycle pulse from the core; all inputs synchronous to MCLK
// Notes: reserved mode codes make the sleep instruction a no-operation
// Functional notes
// - Mode 010 with sleep enters Power-down; oscillator stops, async wake logic runs.
// - Power-down wakes only on resets, watchdog irq, address match, level or pin-change.
// - Power-down halts every generated clock.
// - Level wake vanishing before start-up ends wakes without raising the interrupt.
// - Power-down wake waits a fuse-selected start-up period.
// - Mode 011 enters Power-save: Power-down but timer 2 keeps running.
// - Timer 2 wakes Power-save only with its mask bit and global enable set.
// - Timer oscillator runs only if async; main clock only if timer 2 synchronous.
// - Mode 110 with crystal enters Standby; oscillator stays, wake in six cycles.
// - Mode 111 with crystal enters Extended Standby; wake in six cycles.
// - A stopped peripheral is frozen and its registers cannot be accessed.
// - Clearing the bit restarts the clock with state as before.
// - Peripheral shutdown acts in active and Idle; deeper modes stop clocks anyway.
// - An enabled ADC stays enabled in sleep; re-enable forces extended conversion.
// - Comparator off in deep sleep; a reference it uses stays on.
// - Input buffers off when both I/O and ADC clocks stop.
// - Fuse-enabled brown-out detector stays on in every mode.
// - An enabled watchdog keeps running in every mode.
// - Debug fuse keeps the main clock source on in every sleep mode.
// - Internal reference on only while brown-out, comparator or ADC needs it.
// - Sleep needs the sleep-enable bit set when the instruction executes.
// - Interrupt wake halts four cycles after start-up, then runs the handler.

`timescale 1ns/10ps

module smg_top #(
    parameter int START_MID_CYC = 16384,
    parameter int START_LONG_CYC = 65536,
    parameter int NPERIPH = smg_pkg::NPERIPH
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic CE,
    input wire logic SLEEP_INSTR,
    input wire logic SLEEP_ENABLE_BIT,
    input wire logic [2:0] SLEEP_MODE_SELECT,
    input wire logic [3:0] CLOCK_SOURCE_FUSE,
    input wire logic [1:0] STARTUP_TIME_FUSE,
    input wire logic [2:0] BROWNOUT_LEVEL_FUSE,
    input wire logic DEBUG_LINK_ENABLE_FUSE,
    input wire smg_pkg::smg_wake_s WAKE_SRC,
    input wire smg_pkg::smg_t2_s TIMER2_CFG,
    input wire logic [7:0] PROCESSOR_STATUS_WORD,
    input wire logic [NPERIPH-1:0] PERIPHERAL_CLOCK_OFF_REG,
    input wire logic [NPERIPH-1:0] PERIPH_REG_REQ,
    input wire logic ADC_ENABLE,
    input wire logic ADC_CONV_DONE,
    input wire logic ACOMP_ENABLE,
    input wire logic ACOMP_USES_VREF,
    input wire logic WDT_ENABLE,
    output smg_pkg::smg_clk_s CLOCK_EN,
    output logic [NPERIPH-1:0] PERIPH_CLK_EN,
    output logic [NPERIPH-1:0] PERIPH_REG_GRANT,
    output logic CPU_HALT,
    output logic IRQ_TAKE,
    output logic RESET_WAKE,
    output logic RESUME,
    output logic ADC_EN,
    output logic ADC_EXT_CONV,
    output logic ACOMP_EN,
    output logic VREF_EN,
    output logic INPUT_BUF_EN,
    output logic WAKE_BUF_EN,
    output logic BOD_EN,
    output logic WDT_RUN
);
    localparam int W = smg_pkg::WAKE_W;

    logic [1:0] rsync_q;
    logic rst_n;
    smg_pkg::smg_state_e state_q, state_d;
    logic [2:0] mode_q, mode_d;
    smg_pkg::smg_clk_s clk_q, clk_d;
    logic [1:0] halt_q, halt_d;
    logic by_reset_q, by_reset_d;
    logic irq_ok_q, irq_ok_d;
    logic irq_q, irq_d, rwake_q, rwake_d, resume_q, resume_d, halt_out_q, halt_out_d;
    logic tmr_load, tmr_last;
    logic [W-1:0] tmr_val;
    logic gie, bod_on, xtal;
    logic adc_en_q, adc_en_d, adc_prev_q, ext_conv_q, ext_conv_d;
    logic acomp_q, acomp_d, vref_q, vref_d, inbuf_q, inbuf_d, wbuf_q, bod_q, wdt_q;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rsync_q <= 2'h0;
        end else if (CE) begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rst_n = rsync_q[1];

    assign gie = PROCESSOR_STATUS_WORD[smg_pkg::PSW_GIE_BIT];
    assign bod_on = (BROWNOUT_LEVEL_FUSE != smg_pkg::BOD_FUSE_OFF);
    assign xtal = CLOCK_SOURCE_FUSE[smg_pkg::CKSRC_XTAL_BIT];

    // modes that stop both the I/O clock and the ADC clock
    function automatic logic is_deep(input logic [2:0] m);
        return (m != smg_pkg::MODE_IDLE) && (m != smg_pkg::MODE_ADCNR);
    endfunction

    // standby modes need a crystal; without one they fall back to the plain mode
    function automatic logic [2:0] eff_mode(input logic [2:0] m, input logic xt);
        if (m == smg_pkg::MODE_STBY && !xt) begin
            return smg_pkg::MODE_PDOWN;
        end else if (m == smg_pkg::MODE_XSTBY && !xt) begin
            return smg_pkg::MODE_PSAVE;
        end
        return m;
    endfunction

    // clock domains left running in each mode
    function automatic smg_pkg::smg_clk_s mode_clocks(input logic [2:0] m, input smg_pkg::smg_t2_s t2,
                                                      input logic dbg);
        smg_pkg::smg_clk_s c;
        logic t2a;
        logic t2s;
        c = '0;
        t2a = t2.enabled && t2.async_clk;
        t2s = t2.enabled && t2.sync_clk;
        case (m)
            smg_pkg::MODE_IDLE: begin
                c = smg_pkg::CLK_ALL_ON;
                c.cpu = 1'b0;
                c.flash = 1'b0;
                c.timer_osc = t2a;
            end
            smg_pkg::MODE_ADCNR: begin
                c.adc = 1'b1;
                c.asy = 1'b1;
                c.main_osc = 1'b1;
                c.timer_osc = t2a;
            end
            smg_pkg::MODE_PDOWN: begin
                c = '0;
            end
            smg_pkg::MODE_STBY: begin
                c.main_osc = 1'b1;
            end
            smg_pkg::MODE_PSAVE, smg_pkg::MODE_XSTBY: begin
                c.asy = t2a;
                c.timer_osc = t2a;
                c.main_osc = t2s || (m == smg_pkg::MODE_XSTBY);
                c.t2_sync = t2s;
            end
            default: begin
                c = smg_pkg::CLK_ALL_ON;
            end
        endcase
        if (dbg) begin
            c.main_osc = 1'b1;
        end
        return c;
    endfunction

    // wake qualification; resets excluded when asking whether an interrupt is due
    function automatic logic wake_hit(input logic [2:0] m, input smg_pkg::smg_wake_s w,
                                      input smg_pkg::smg_t2_s t2, input logic ie, input logic rst);
        logic base;
        logic t2hit;
        base = w.wdt_irq || w.twi_match || w.ext_irq_zero || w.ext_irq_one || w.pin_change;
        if (rst) begin
            base = base || w.ext_reset || w.wdt_reset || w.bod_reset;
        end
        t2hit = t2.enabled && ie && ((t2.timer2_irq_mask & t2.evt) != 3'h0);
        case (m)
            smg_pkg::MODE_IDLE: return base || t2hit || w.other_irq;
            smg_pkg::MODE_ADCNR, smg_pkg::MODE_PSAVE, smg_pkg::MODE_XSTBY: return base || t2hit;
            default: return base;
        endcase
    endfunction

    // start-up period chosen from the fuses, short fixed wake for standby
    always_comb begin
        if (mode_q == smg_pkg::MODE_STBY || mode_q == smg_pkg::MODE_XSTBY) begin
            tmr_val = W'(smg_pkg::STBY_WAKE_CYC);
        end else if (!is_deep(mode_q)) begin
            tmr_val = W'(smg_pkg::NOSTOP_WAKE_CYC);
        end else if (STARTUP_TIME_FUSE[smg_pkg::SUT_LONG_BIT]) begin
            tmr_val = W'(START_LONG_CYC);
        end else if (STARTUP_TIME_FUSE == smg_pkg::SUT_SHORT) begin
            tmr_val = W'(smg_pkg::START_SHORT_CYC);
        end else begin
            tmr_val = W'(START_MID_CYC);
        end
    end

    smg_wake_timer #(
        .W(W)
    ) u_wake_timer (
        .clk(MCLK),
        .rst_n(rst_n),
        .ce(CE),
        .load(tmr_load),
        .load_val(tmr_val),
        .last(tmr_last)
    );

    // sleep sequencer: entry, wait, start-up, four-cycle halt, resume
    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        clk_d = clk_q;
        halt_d = halt_q;
        by_reset_d = by_reset_q;
        irq_ok_d = irq_ok_q;
        irq_d = 1'b0;
        rwake_d = 1'b0;
        resume_d = 1'b0;
        tmr_load = 1'b0;
        case (state_q)
            smg_pkg::ST_ACTIVE: begin
                if (SLEEP_INSTR && SLEEP_ENABLE_BIT && SLEEP_MODE_SELECT != smg_pkg::MODE_RSV4 &&
                    SLEEP_MODE_SELECT != smg_pkg::MODE_RSV5) begin
                    mode_d = eff_mode(SLEEP_MODE_SELECT, xtal);
                    clk_d = mode_clocks(mode_d, TIMER2_CFG, DEBUG_LINK_ENABLE_FUSE);
                    state_d = smg_pkg::ST_SLEEP;
                end
            end
            smg_pkg::ST_SLEEP: begin
                if (wake_hit(mode_q, WAKE_SRC, TIMER2_CFG, gie, 1'b1)) begin
                    by_reset_d = WAKE_SRC.ext_reset || WAKE_SRC.wdt_reset || WAKE_SRC.bod_reset;
                    clk_d.main_osc = 1'b1;
                    tmr_load = 1'b1;
                    state_d = smg_pkg::ST_START;
                end
            end
            smg_pkg::ST_START: begin
                if (tmr_last) begin
                    // level sources are sampled again once start-up has finished
                    irq_ok_d = wake_hit(mode_q, WAKE_SRC, TIMER2_CFG, gie, 1'b0);
                    clk_d = smg_pkg::CLK_ALL_ON;
                    clk_d.cpu = 1'b0;
                    halt_d = 2'(smg_pkg::HALT_CYC - 1);
                    state_d = smg_pkg::ST_HALT;
                end
            end
            default: begin
                if (halt_q == 2'h0) begin
                    clk_d = smg_pkg::CLK_ALL_ON;
                    irq_d = irq_ok_q && !by_reset_q;
                    rwake_d = by_reset_q;
                    resume_d = 1'b1;
                    state_d = smg_pkg::ST_ACTIVE;
                end else begin
                    halt_d = halt_q - 2'h1;
                end
            end
        endcase
        halt_out_d = (state_d != smg_pkg::ST_ACTIVE);
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= smg_pkg::ST_ACTIVE;
            mode_q <= smg_pkg::MODE_IDLE;
            clk_q <= smg_pkg::CLK_ALL_ON;
            halt_q <= 2'h0;
            by_reset_q <= 1'b0;
            irq_ok_q <= 1'b0;
            irq_q <= 1'b0;
            rwake_q <= 1'b0;
            resume_q <= 1'b0;
            halt_out_q <= 1'b0;
        end else if (CE) begin
            state_q <= state_d;
            mode_q <= mode_d;
            clk_q <= clk_d;
            halt_q <= halt_d;
            by_reset_q <= by_reset_d;
            irq_ok_q <= irq_ok_d;
            irq_q <= irq_d;
            rwake_q <= rwake_d;
            resume_q <= resume_d;
            halt_out_q <= halt_out_d;
        end
    end

    // input buffers follow the clocks actually running; analog helpers follow their enables, the comparator also the sleep mode
    always_comb begin
        adc_en_d = ADC_ENABLE;
        ext_conv_d = ext_conv_q;
        if (ADC_CONV_DONE) begin
            ext_conv_d = 1'b0;
        end
        if (ADC_ENABLE && !adc_prev_q) begin
            ext_conv_d = 1'b1; // set wins over a same-cycle completion
        end
        acomp_d = ACOMP_ENABLE && (state_q == smg_pkg::ST_ACTIVE || !is_deep(mode_q));
        vref_d = bod_on || ADC_ENABLE || (ACOMP_ENABLE && ACOMP_USES_VREF);
        inbuf_d = clk_q.io || clk_q.adc;
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            adc_en_q <= 1'b0;
            adc_prev_q <= 1'b0;
            ext_conv_q <= 1'b0;
            acomp_q <= 1'b0;
            vref_q <= 1'b0;
            inbuf_q <= 1'b0;
            wbuf_q <= 1'b0;
            bod_q <= 1'b0;
            wdt_q <= 1'b0;
        end else if (CE) begin
            adc_en_q <= adc_en_d;
            adc_prev_q <= ADC_ENABLE;
            ext_conv_q <= ext_conv_d;
            acomp_q <= acomp_d;
            vref_q <= vref_d;
            inbuf_q <= inbuf_d;
            wbuf_q <= 1'b1; // wake-detect buffers are never switched off
            bod_q <= bod_on;
            wdt_q <= WDT_ENABLE;
        end
    end

    smg_periph_gate #(
        .N(NPERIPH)
    ) u_periph_gate (
        .clk(MCLK),
        .rst_n(rst_n),
        .ce(CE),
        .clk_off(PERIPHERAL_CLOCK_OFF_REG),
        .io_run(clk_q.io),
        .adc_run(clk_q.adc),
        .asy_run(clk_q.asy),
        .t2_async(TIMER2_CFG.async_clk),
        .reg_req(PERIPH_REG_REQ),
        .pclk_en_q(PERIPH_CLK_EN),
        .grant_q(PERIPH_REG_GRANT)
    );

    assign CLOCK_EN = clk_q;
    assign CPU_HALT = halt_out_q;
    assign IRQ_TAKE = irq_q;
    assign RESET_WAKE = rwake_q;
    assign RESUME = resume_q;
    assign ADC_EN = adc_en_q;
    assign ADC_EXT_CONV = ext_conv_q;
    assign ACOMP_EN = acomp_q;
    assign VREF_EN = vref_q;
    assign INPUT_BUF_EN = inbuf_q;
    assign WAKE_BUF_EN = wbuf_q;
    assign BOD_EN = bod_q;
    assign WDT_RUN = wdt_q;

    default clocking dc @(posedge MCLK); endclocking
    default disable iff (!rst_n || !CE);

    sequence s_stby_wake;
        state_q == smg_pkg::ST_SLEEP && mode_q == smg_pkg::MODE_STBY &&
            wake_hit(mode_q, WAKE_SRC, TIMER2_CFG, gie, 1'b1);
    endsequence
    sequence s_halt_entry;
        state_q == smg_pkg::ST_START ##1 state_q == smg_pkg::ST_HALT;
    endsequence

    AST_PDOWN_ENTRY: assert property (state_q == smg_pkg::ST_ACTIVE && SLEEP_INSTR && SLEEP_ENABLE_BIT &&
        SLEEP_MODE_SELECT == smg_pkg::MODE_PDOWN |=> state_q == smg_pkg::ST_SLEEP &&
        CLOCK_EN.main_osc == DEBUG_LINK_ENABLE_FUSE && !CLOCK_EN.io)
        else $error("power-down entry wrong");
    AST_NO_SE: assert property (state_q == smg_pkg::ST_ACTIVE && SLEEP_INSTR && !SLEEP_ENABLE_BIT
        |=> state_q == smg_pkg::ST_ACTIVE)
        else $error("slept without sleep enable");
    AST_RSV_NOP: assert property (state_q == smg_pkg::ST_ACTIVE && SLEEP_INSTR &&
        SLEEP_MODE_SELECT == smg_pkg::MODE_RSV5 |=> state_q == smg_pkg::ST_ACTIVE && CLOCK_EN.cpu)
        else $error("reserved mode gated clocks");
    AST_PD_CLOCKS: assert property (state_q == smg_pkg::ST_SLEEP && mode_q == smg_pkg::MODE_PDOWN
        |-> !(CLOCK_EN.cpu || CLOCK_EN.io || CLOCK_EN.adc || CLOCK_EN.asy || CLOCK_EN.timer_osc))
        else $error("clock running in power-down");
    AST_PD_STAY: assert property (state_q == smg_pkg::ST_SLEEP && mode_q == smg_pkg::MODE_PDOWN &&
        !wake_hit(mode_q, WAKE_SRC, TIMER2_CFG, gie, 1'b1) |=> state_q == smg_pkg::ST_SLEEP)
        else $error("power-down left without a wake source");
    AST_PS_T2: assert property (state_q == smg_pkg::ST_SLEEP && mode_q == smg_pkg::MODE_PSAVE &&
        TIMER2_CFG.enabled && gie && (TIMER2_CFG.timer2_irq_mask & TIMER2_CFG.evt) != 3'h0
        |=> state_q == smg_pkg::ST_START)
        else $error("timer 2 event did not wake power-save");
    AST_STBY_SIX: assert property (s_stby_wake |=> (state_q == smg_pkg::ST_START)[*6] ##1
        state_q == smg_pkg::ST_HALT)
        else $error("standby wake not six cycles");
    AST_HALT_FOUR: assert property (s_halt_entry |=> (state_q == smg_pkg::ST_HALT)[*3] ##1
        state_q == smg_pkg::ST_ACTIVE && RESUME && !CPU_HALT)
        else $error("halt after start-up not four cycles");
    AST_LEVEL_LOST: assert property (state_q == smg_pkg::ST_HALT && !irq_ok_q |=> !IRQ_TAKE)
        else $error("interrupt raised after level vanished");
    AST_ACOMP_DEEP: assert property (state_q == smg_pkg::ST_SLEEP && is_deep(mode_q) |=> !ACOMP_EN)
        else $error("comparator left on in deep sleep");
    AST_KEEP_ON: assert property (bod_on && WDT_ENABLE && ADC_ENABLE |=>
        BOD_EN && WDT_RUN && ADC_EN && VREF_EN)
        else $error("helper dropped during sleep");
endmodule // smg_top

// >>> verification/smg_periph_model.sv
// Purpose: peripheral behind one gated clock
// Assumes: en is its clock enable
// Notes: count holds while en is low
`timescale 1ns/10ps
module smg_periph_model (
    input wire logic clk,
    input wire logic en,
    output logic [7:0] cnt
);
    initial cnt = 8'h00;
    // state moves only on an enabled clock, so a restart resumes it
    always @(posedge clk) begin
        if (en) begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // smg_periph_model

// >>> verification/test_smg_top.sv
// Purpose: self-checking bench for the sleep controller
// Assumes: start-up counts shortened to 20 and 40
// Notes: inputs change at the falling edge
`timescale 1ns/10ps
module test_smg_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic si = 1'b0;
    logic se = 1'b0;
    logic aen = 1'b0;
    logic ce = 1'b1;
    logic dbg = 1'b0;
    logic done = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [1:0] startup_time_fuse = 2'h1;
    smg_pkg::smg_wake_s wake = '0;
    smg_pkg::smg_t2_s t2 = '0;
    logic [7:0] psw = 8'h00;
    logic [7:0] off = 8'h00;
    logic [7:0] req = 8'h00;
    logic [7:0] pen, gnt, cnt;
    smg_pkg::smg_clk_s cen;
    logic halt, irq, rw, res, adc, ext, acmp, vref, ibuf, wbuf, bod, wdt;
    int mismatches = 0;
    int samples_checked = 0;
    int n;
    always #5 clk = ~clk;
    smg_top #(.START_MID_CYC(20), .START_LONG_CYC(40)) u_smg_top (.MCLK(clk), .ARST_N(rst_n), .CE(ce),
        .SLEEP_INSTR(si), .SLEEP_ENABLE_BIT(se), .SLEEP_MODE_SELECT(mode), .CLOCK_SOURCE_FUSE(4'h8),
        .STARTUP_TIME_FUSE(startup_time_fuse), .BROWNOUT_LEVEL_FUSE(3'h4), .DEBUG_LINK_ENABLE_FUSE(dbg), .WAKE_SRC(wake),
        .TIMER2_CFG(t2), .PROCESSOR_STATUS_WORD(psw), .PERIPHERAL_CLOCK_OFF_REG(off), .PERIPH_REG_REQ(req),
        .ADC_ENABLE(aen), .ADC_CONV_DONE(done), .ACOMP_ENABLE(aen), .ACOMP_USES_VREF(1'b1), .WDT_ENABLE(aen),
        .CLOCK_EN(cen), .PERIPH_CLK_EN(pen), .PERIPH_REG_GRANT(gnt), .CPU_HALT(halt), .IRQ_TAKE(irq),
        .RESET_WAKE(rw), .RESUME(res), .ADC_EN(adc), .ADC_EXT_CONV(ext), .ACOMP_EN(acmp), .VREF_EN(vref),
        .INPUT_BUF_EN(ibuf), .WAKE_BUF_EN(wbuf), .BOD_EN(bod), .WDT_RUN(wdt));
    smg_periph_model u_smg_periph_model (.clk(clk), .en(pen[1]), .cnt(cnt));
    // wake latency: one sample cycle, start-up, then the halt
    function automatic int wexp(input int st);
        return 1 + st + smg_pkg::HALT_CYC;
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic sleep(input logic [2:0] m, input logic e);
        @(negedge clk);
        mode = m;
        se = e;
        si = 1'b1;
        @(negedge clk);
        si = 1'b0;
    endtask
    // bounded wait for resume; hold is how many cycles the source stays up
    task automatic wk(input smg_pkg::smg_wake_s w, input int hold);
        wake = w;
        n = 0;
        while (res !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
            if (n == hold) wake = '0;
        end
        wake = '0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #300us;
        mismatches++;
        test_done();
    end
    initial begin
        void'($urandom(26269));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        aen = 1'b1;
        repeat (4) @(negedge clk);
        chk("ext_conv", ext, 1);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        chk("ext_clear", ext, 0);
        for (int i = 0; i < 3; i++) begin
            sleep((i == 2) ? 3'h2 : 3'h4 + 3'(i), i != 2); // reserved codes with sleep enable set, then power-down with it clear
            chk("halt_refused", halt, 0);
        end
        sleep(3'h2, 1'b1);
        chk("pdown_clk", cen, 8'h00);
        // helper outputs follow the sleep state one cycle after the clocks
        @(negedge clk);
        chk("helpers", {adc, acmp, vref, ibuf, wbuf, bod, wdt}, 7'h57);
        wake = 9'h001;
        repeat (5) @(negedge clk);
        chk("pdown_other", halt, 1);
        wk(9'h008, 1);
        chk("pdown_lat", 16'(n), 16'(wexp(20)));
        chk("lvl_irq", irq, 0);
        for (int m = 6; m < 8; m++) begin
            sleep(3'(m), 1'b1);
            chk("stby_clk", cen, 8'h04);
            wk(9'h008, 999);
            chk("stby_lat", 16'(n), 16'(wexp(smg_pkg::STBY_WAKE_CYC)));
            chk("stby_irq", irq, 1);
        end
        t2 = 9'h188; // timer 2 enabled on its own oscillator with mask bit 0 set
        sleep(3'h3, 1'b1);
        chk("psave_clk", cen, 8'h0A);
        t2 = 9'h189;
        repeat (5) @(negedge clk);
        chk("psave_nogie", halt, 1);
        psw = 8'h80;
        wk('0, 999);
        chk("psave_lat", 16'(n), 16'(wexp(20)));
        t2 = '0;
        // debug fuse keeps the main source up; a reset wake gives no interrupt
        dbg = 1'b1;
        startup_time_fuse = 2'h2;
        sleep(3'h2, 1'b1);
        chk("dbg_clk", cen, 8'h04);
        wk(9'h100, 999);
        chk("rst_lat", 16'(n), 16'(wexp(40)));
        chk("rst_wake", {rw, irq}, 2'h2);
        dbg = 1'b0;
        repeat (20) begin
            @(negedge clk);
            off = 8'($urandom);
            req = 8'($urandom);
            @(negedge clk);
            chk("periph", {pen, gnt}, {~off, req & ~off});
        end
        off = 8'h02; // stop the clock of peripheral 1, which drives the counting model
        @(negedge clk);
        n = cnt;
        repeat (3) @(negedge clk);
        chk("frozen", cnt, 16'(n));
        off = 8'h00;
        repeat (3) @(negedge clk);
        chk("resumed", cnt, 16'(8'(n + 2)));
        // clock enable low freezes the gate outputs
        ce = 1'b0;
        off = 8'hFF;
        repeat (2) @(negedge clk);
        chk("ce_freeze", pen, 8'hFF);
        ce = 1'b1;
        @(negedge clk);
        chk("ce_run", pen, 8'h00);
        test_done();
    end
endmodule // test_smg_top
